// [logic/monitor_irq_pkg.sv]
// constants shared by the monitor interrupt and thermal alarm block
// assumes an 8-bit register port with 8-bit offsets and a 125 MHz system clock
package monitor_irq_pkg;

    localparam int CLK_HZ = 125_000_000;

    // register offsets
    localparam logic [7:0] ADDR_LOCAL_HW_LIMIT = 8'h13;
    localparam logic [7:0] ADDR_REMOTE_HW_LIMIT = 8'h14;
    localparam logic [7:0] ADDR_CHANNEL_MODE = 8'h16;
    localparam logic [7:0] ADDR_THIRD_HW_LIMIT = 8'h17;
    localparam logic [7:0] ADDR_FOURTH_HW_LIMIT = 8'h18;
    localparam logic [7:0] ADDR_ANALOG_OUT = 8'h19;
    localparam logic [7:0] ADDR_CONFIG_FIRST = 8'h40;
    localparam logic [7:0] ADDR_STATUS_FIRST = 8'h41;
    localparam logic [7:0] ADDR_STATUS_MIRROR_SECOND = 8'h42;
    localparam logic [7:0] ADDR_STATUS_SECOND = 8'h43;
    localparam logic [7:0] ADDR_MASK_FIRST = 8'h44;
    localparam logic [7:0] ADDR_MASK_SECOND = 8'h45;
    localparam logic [7:0] ADDR_INTRUSION_CLEAR = 8'h46;
    localparam logic [7:0] ADDR_HW_TRIP_STATUS = 8'h47;
    localparam logic [7:0] ADDR_CONFIG_SECOND = 8'h4A;
    localparam logic [7:0] ADDR_STATUS_MIRROR_FIRST = 8'h4C;

    // configuration register 1 fields
    localparam int CFG1_START = 0;
    localparam int CFG1_INT_ENABLE = 1;
    localparam int CFG1_THERMAL_ALARM_N_ENABLE = 2;
    localparam int CFG1_INT_CLEAR = 3;
    localparam int CFG1_THERMAL_ALARM_N_CLEAR = 6;
    // configuration register 2 fields
    localparam int CFG2_TEMP_INT_MASK = 0;
    localparam int CFG2_ACPI_MODE = 3;
    localparam int CFG2_IRQ3_ENABLE = 6;
    localparam int CFG2_IRQ4_ENABLE = 7;
    // channel mode fields and the intrusion clear bit
    localparam int CHMODE_EXTERNAL_REQUEST_INPUTS_ENABLE = 4;
    localparam int CHMODE_VID_AS_IRQ = 7;
    localparam int INTRUSION_CLEAR_BIT = 7;

    // status bit indices over the 16-bit status pair (second register in bits 15:8)
    localparam logic [3:0] STATUS_LOCAL_TEMP = 4'h4;
    localparam logic [3:0] STATUS_REMOTE_TEMP = 4'h5;
    localparam logic [3:0] STATUS_INTRUSION = 4'hC;
    localparam logic [3:0] STATUS_THERMAL_ALARM_N = 4'hD;
    localparam logic [15:0] TEMP_STATUS_MASK = 16'h2030;

    // level polarity of the reused voltage-code pins: 1 marks active low
    localparam logic [4:0] IRQ_ACTIVE_LOW = 5'h07;

    // reset values and the forced fan level
    localparam logic [7:0] CONFIG_FIRST_RST = 8'h08;
    localparam logic [7:0] HW_LIMIT_RST = 8'h7F;
    localparam logic [7:0] FAN_FULL = 8'hFF;

    // thermal hysteresis and debounce
    localparam logic [8:0] HW_HYSTERESIS_DEG = 9'h005;
    localparam logic [1:0] HW_CONSECUTIVE = 2'h3;

    // intrusion reset pulse
    localparam int INTRUSION_PULSE_MS = 20;
    localparam int INTRUSION_PULSE_CYCLES = INTRUSION_PULSE_MS * (CLK_HZ / 1000);

endpackage

// [logic/monitor_irq_thermal_alarm_n.sv]
// interrupt, intrusion and thermal alarm logic of a system hardware monitor
// assumes measurements arrive as one-cycle strobes with their value and limits from a measurement sequencer,
// all pin inputs synchronous to clk_i, and an 8-bit register port with read data one cycle later
//
// Function
// - each comparison result rewrites its status bit
// - mask bit one blocks that status bit
// - unmasked status bits OR into low interrupt
// - interrupt needs enable set, clear bit low
// - status read returns contents, then clears them
// - interrupt-clear releases output, keeps status contents
// - mirrors copy status updates, reads clear nothing
// - voltage-code pins become level interrupt inputs
// - each pin input enabled individually, never latched
// - intrusion level interrupts; clear pulls pin low
// - cleared high-temp interrupt rearms on new causes
// - cleared low-temp interrupt rearms on new causes
// - thermal enable and default/ACPI mode select
// - temperature mask hides general interrupt; writing it set clears hardware trips
// - external thermal low forces fan, raises interrupt
// - default mode alarm sets on high, releases
// - status-read release reasserts if still hot
// - thermal-clear release holds until bit cleared
// - three hot hardware readings trip alarm, fan
// - three readings five degrees below release trip
// - ACPI mode follows only hardware limits
// - interrupt-clear bit halts monitoring until zero
`timescale 1ns/1ps

module monitor_irq_thermal_alarm_n
    import monitor_irq_pkg::*;
#(
    parameter int INTRUSION_CYCLES = INTRUSION_PULSE_CYCLES
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic meas_valid_i,
    input wire logic [3:0] meas_index_i,
    input wire logic [7:0] meas_value_i,
    input wire logic [7:0] meas_high_i,
    input wire logic [7:0] meas_low_i,
    output logic monitor_run_o,
    input wire logic [4:0] voltage_code_inputs_i,
    input wire logic intrusion_pin_i,
    output logic intrusion_pin_o,
    output logic intrusion_pin_oe_o,
    input wire logic thermal_alarm_n_i,
    output logic thermal_alarm_n_o,
    output logic thermal_alarm_n_oe_o,
    output logic int_n_o,
    output logic [7:0] fan_level_o
);

    typedef struct packed {
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] chmode;
        logic [7:0] analog;
        logic [3:0][7:0] hw_lim;
        logic [15:0] mask;
        logic [15:0] status;
        logic [15:0] mirror;
        logic [1:0] suppress;
        logic [1:0][1:0] last_dir;
        logic [1:0][7:0] snap_high;
        logic [1:0][7:0] snap_low;
        logic [1:0][1:0] over_cnt;
        logic [1:0][1:0] under_cnt;
        logic [1:0] hw_trip;
        logic thermal_alarm_n_soft;
        logic intr_pulse;
        logic [31:0] intr_cnt;
        logic [7:0] rdata;
        logic int_n;
        logic thermal_alarm_n_oe;
        logic [7:0] fan;
        logic run;
    } state_t;

    state_t q;
    state_t d;

    // temperature channel of a status index, bit 1 flags a temperature channel
    function automatic logic [1:0] temp_chan(input logic [3:0] idx);
        temp_chan = 2'h0;
        if (idx == STATUS_LOCAL_TEMP)
        begin
            temp_chan = 2'h2;
        end
        else if (idx == STATUS_REMOTE_TEMP)
        begin
            temp_chan = 2'h3;
        end
    endfunction

    function automatic logic is_cool(input logic [7:0] value, input logic [7:0] lim);
        is_cool = ({1'b0, value} + HW_HYSTERESIS_DEG) <= {1'b0, lim};
    endfunction

    function automatic logic [1:0] sat_inc(input logic [1:0] cnt);
        sat_inc = (cnt == HW_CONSECUTIVE) ? cnt : cnt + 2'h1;
    endfunction

    logic clear_evt;
    logic read_st1;
    logic read_st2;
    logic ext_thermal_alarm_n_low;
    logic meas_high;
    logic meas_low;
    logic [1:0] tchan;
    logic tsel;
    logic hw_over;
    logic hw_cool;
    logic [15:0] suppress_vec;
    logic [15:0] temp_gate;
    logic [4:0] irq_active;
    logic [4:0] irq_enable;
    logic hw_any;
    logic thermal_alarm_n_on;
    logic [7:0] rd_val;

    always_comb
    begin
        d = q;
        clear_evt = reg_wr_i && reg_addr_i == ADDR_CONFIG_FIRST && reg_wdata_i[CFG1_INT_CLEAR];
        read_st1 = reg_rd_i && reg_addr_i == ADDR_STATUS_FIRST;
        read_st2 = reg_rd_i && reg_addr_i == ADDR_STATUS_SECOND;
        // our own drive reads back low, so only a low we are not driving is external
        ext_thermal_alarm_n_low = !thermal_alarm_n_i && !q.thermal_alarm_n_oe;
        meas_high = meas_value_i > meas_high_i;
        meas_low = meas_value_i < meas_low_i;
        tchan = temp_chan(meas_index_i);
        tsel = tchan[0];
        hw_over = meas_value_i > q.hw_lim[{1'b0, tsel}] || meas_value_i > q.hw_lim[{1'b1, tsel}];
        hw_cool = is_cool(meas_value_i, q.hw_lim[{1'b0, tsel}]) && is_cool(meas_value_i, q.hw_lim[{1'b1, tsel}]);

        // register read, data stands in the next cycle only
        case (reg_addr_i)
            ADDR_LOCAL_HW_LIMIT: rd_val = q.hw_lim[0];
            ADDR_REMOTE_HW_LIMIT: rd_val = q.hw_lim[1];
            ADDR_THIRD_HW_LIMIT: rd_val = q.hw_lim[2];
            ADDR_FOURTH_HW_LIMIT: rd_val = q.hw_lim[3];
            ADDR_CHANNEL_MODE: rd_val = q.chmode;
            ADDR_ANALOG_OUT: rd_val = q.analog;
            ADDR_CONFIG_FIRST: rd_val = q.cfg1;
            ADDR_CONFIG_SECOND: rd_val = q.cfg2;
            ADDR_STATUS_FIRST: rd_val = q.status[7:0];
            ADDR_STATUS_SECOND: rd_val = q.status[15:8];
            ADDR_STATUS_MIRROR_FIRST: rd_val = q.mirror[7:0];
            ADDR_STATUS_MIRROR_SECOND: rd_val = q.mirror[15:8];
            ADDR_MASK_FIRST: rd_val = q.mask[7:0];
            ADDR_MASK_SECOND: rd_val = q.mask[15:8];
            ADDR_INTRUSION_CLEAR: rd_val = {q.intr_pulse, 7'h00};
            ADDR_HW_TRIP_STATUS: rd_val = {6'h00, q.hw_trip};
            default: rd_val = 8'h00;
        endcase
        d.rdata = reg_rd_i ? rd_val : 8'h00;

        // a read clears the register it returned; later sets in this cycle still win
        if (read_st1)
        begin
            d.status[7:0] = 8'h00;
        end
        if (read_st2)
        begin
            d.status[15:8] = 8'h00;
            d.thermal_alarm_n_soft = 1'b0;
        end
        // a cleared temperature interrupt stays quiet while its cause persists
        if (clear_evt || read_st1)
        begin
            d.suppress[0] = q.suppress[0] | q.status[STATUS_LOCAL_TEMP];
            d.suppress[1] = q.suppress[1] | q.status[STATUS_REMOTE_TEMP];
        end

        if (reg_wr_i)
        begin
            case (reg_addr_i)
                ADDR_LOCAL_HW_LIMIT: d.hw_lim[0] = reg_wdata_i;
                ADDR_REMOTE_HW_LIMIT: d.hw_lim[1] = reg_wdata_i;
                ADDR_THIRD_HW_LIMIT: d.hw_lim[2] = reg_wdata_i;
                ADDR_FOURTH_HW_LIMIT: d.hw_lim[3] = reg_wdata_i;
                ADDR_CHANNEL_MODE: d.chmode = reg_wdata_i;
                ADDR_ANALOG_OUT: d.analog = reg_wdata_i;
                ADDR_CONFIG_FIRST: d.cfg1 = reg_wdata_i;
                ADDR_MASK_FIRST: d.mask[7:0] = reg_wdata_i;
                ADDR_MASK_SECOND: d.mask[15:8] = reg_wdata_i;
                ADDR_CONFIG_SECOND:
                begin
                    d.cfg2 = reg_wdata_i;
                    if (reg_wdata_i[CFG2_TEMP_INT_MASK])
                    begin
                        d.hw_trip = 2'h0;
                        d.over_cnt = '0;
                        d.under_cnt = '0;
                    end
                end
                ADDR_INTRUSION_CLEAR:
                begin
                    if (reg_wdata_i[INTRUSION_CLEAR_BIT] && !q.intr_pulse)
                    begin
                        d.intr_pulse = 1'b1;
                        d.intr_cnt = 32'h0000_0000;
                    end
                end
                default: ;
            endcase
        end

        // intrusion reset pulse, the bit clears itself when the pulse ends
        if (q.intr_pulse)
        begin
            d.intr_cnt = q.intr_cnt + 32'h0000_0001;
            if (q.intr_cnt == 32'(INTRUSION_CYCLES - 1))
            begin
                d.intr_pulse = 1'b0;
            end
        end

        // comparisons are taken only while monitoring runs
        if (meas_valid_i && q.cfg1[CFG1_START] && !q.cfg1[CFG1_INT_CLEAR])
        begin
            d.status[meas_index_i] = meas_high | meas_low;
            d.mirror[meas_index_i] = meas_high | meas_low;
            if (tchan[1])
            begin
                // a new direction or reprogrammed limit lets the interrupt through again
                if ({meas_high, meas_low} != q.last_dir[tsel] || meas_high_i != q.snap_high[tsel]
                    || meas_low_i != q.snap_low[tsel])
                begin
                    d.suppress[tsel] = 1'b0;
                end
                d.last_dir[tsel] = {meas_high, meas_low};
                d.snap_high[tsel] = meas_high_i;
                d.snap_low[tsel] = meas_low_i;
                if (meas_high)
                begin
                    d.thermal_alarm_n_soft = 1'b1;
                    d.status[STATUS_THERMAL_ALARM_N] = 1'b1;
                    d.mirror[STATUS_THERMAL_ALARM_N] = 1'b1;
                end
                else if (meas_low)
                begin
                    d.thermal_alarm_n_soft = 1'b0;
                end
                d.over_cnt[tsel] = hw_over ? sat_inc(q.over_cnt[tsel]) : 2'h0;
                d.under_cnt[tsel] = hw_cool ? sat_inc(q.under_cnt[tsel]) : 2'h0;
                if (d.over_cnt[tsel] == HW_CONSECUTIVE)
                begin
                    d.hw_trip[tsel] = 1'b1;
                end
                else if (d.under_cnt[tsel] == HW_CONSECUTIVE)
                begin
                    d.hw_trip[tsel] = 1'b0;
                end
            end
            else if ((meas_high | meas_low) && !q.status[meas_index_i])
            begin
                d.suppress = 2'h0;
            end
        end

        if (ext_thermal_alarm_n_low)
        begin
            d.status[STATUS_THERMAL_ALARM_N] = 1'b1;
            d.mirror[STATUS_THERMAL_ALARM_N] = 1'b1;
            d.suppress = 2'h0;
        end
        if (intrusion_pin_i && !q.intr_pulse)
        begin
            d.status[STATUS_INTRUSION] = 1'b1;
            d.mirror[STATUS_INTRUSION] = 1'b1;
        end
        if (d.cfg1[CFG1_THERMAL_ALARM_N_CLEAR])
        begin
            d.thermal_alarm_n_soft = 1'b0;
        end

        // general interrupt
        suppress_vec = 16'h0000;
        suppress_vec[STATUS_LOCAL_TEMP] = q.suppress[0];
        suppress_vec[STATUS_REMOTE_TEMP] = q.suppress[1];
        temp_gate = q.cfg2[CFG2_TEMP_INT_MASK] ? TEMP_STATUS_MASK : 16'h0000;
        irq_active = voltage_code_inputs_i ^ IRQ_ACTIVE_LOW;
        irq_enable = {q.cfg2[CFG2_IRQ4_ENABLE], q.cfg2[CFG2_IRQ3_ENABLE],
                      q.chmode[CHMODE_EXTERNAL_REQUEST_INPUTS_ENABLE + 2 -: 3]};
        if (!q.chmode[CHMODE_VID_AS_IRQ])
        begin
            irq_enable = 5'h00;
        end
        // pin requests feed the output directly and are never stored
        d.int_n = !(q.cfg1[CFG1_INT_ENABLE] && !q.cfg1[CFG1_INT_CLEAR]
                    && ((|(q.status & ~q.mask & ~temp_gate & ~suppress_vec))
                        || (|(irq_active & irq_enable))));

        // thermal alarm
        hw_any = |q.hw_trip;
        if (q.cfg2[CFG2_ACPI_MODE])
        begin
            thermal_alarm_n_on = hw_any;
        end
        else
        begin
            thermal_alarm_n_on = q.thermal_alarm_n_soft || hw_any;
        end
        d.thermal_alarm_n_oe = q.cfg1[CFG1_THERMAL_ALARM_N_ENABLE] && thermal_alarm_n_on;
        d.fan = (hw_any || ext_thermal_alarm_n_low) ? FAN_FULL : q.analog;
        d.run = d.cfg1[CFG1_START] && !d.cfg1[CFG1_INT_CLEAR];
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            q <= '0;
            q.cfg1 <= CONFIG_FIRST_RST;
            q.hw_lim <= {4{HW_LIMIT_RST}};
            q.int_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_rdata_o = q.rdata;
    assign monitor_run_o = q.run;
    assign intrusion_pin_o = 1'b0;
    assign intrusion_pin_oe_o = q.intr_pulse;
    assign thermal_alarm_n_o = 1'b0;
    assign thermal_alarm_n_oe_o = q.thermal_alarm_n_oe;
    assign int_n_o = q.int_n;
    assign fan_level_o = q.fan;

endmodule

// [sim/monitor_pin_env.sv]
// pin side model: intrusion latch circuit and an external thermal sensor on a pulled-up line
// assumes pin enables and levels from the block and event requests from the bench
`timescale 1ns/1ps
module monitor_pin_env
(
    input wire logic clk_i,
    input wire logic intrusion_event_i,
    input wire logic intrusion_drive_i,
    input wire logic intrusion_oe_i,
    input wire logic thermal_drive_i,
    input wire logic thermal_oe_i,
    input wire logic ext_hot_i,
    output logic intrusion_pin_o,
    output logic thermal_pin_o
);
    logic latch_q = 1'b0;
    // the external latch resets only while the block holds the line low
    always @(posedge clk_i)
    begin
        if (intrusion_oe_i && !intrusion_drive_i)
            latch_q <= 1'b0;
        else if (intrusion_event_i)
            latch_q <= 1'b1;
    end
    assign intrusion_pin_o = intrusion_oe_i ? intrusion_drive_i : latch_q;
    // pull-up wins only when nobody drives the line low
    assign thermal_pin_o = (thermal_oe_i ? thermal_drive_i : 1'b1) && !ext_hot_i;
endmodule

// [sim/monitor_irq_thermal_alarm_n_monitor.sv]
// port checker for the interrupt and thermal alarm block
// assumes it is bound into monitor_irq_thermal_alarm_n with the same pulse length parameter
`timescale 1ns/1ps
module monitor_irq_check
    import monitor_irq_pkg::*;
#(
    parameter int INTRUSION_CYCLES = 16
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic meas_valid_i,
    input wire logic monitor_run_o,
    input wire logic intrusion_pin_o,
    input wire logic intrusion_pin_oe_o,
    input wire logic thermal_alarm_n_i,
    input wire logic thermal_alarm_n_oe_o,
    input wire logic int_n_o,
    input wire logic [7:0] fan_level_o
);
    logic [31:0] hold_q;
    logic cfg_wr;
    assign cfg_wr = reg_wr_i && reg_addr_i == ADDR_CONFIG_FIRST;
    // counts how long the intrusion line has been pulled low so far
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i || !intrusion_pin_oe_o)
            hold_q <= 32'h0;
        else
            hold_q <= hold_q + 32'h1;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_rd(logic [7:0] a);
        reg_rd_i && reg_addr_i == a && !meas_valid_i;
    endsequence
    property p_int_clear;
        cfg_wr && reg_wdata_i[CFG1_INT_CLEAR] |-> ##2 int_n_o;
    endproperty
    property p_int_off;
        cfg_wr && !reg_wdata_i[CFG1_INT_ENABLE] |-> ##2 int_n_o;
    endproperty
    property p_halt;
        cfg_wr && reg_wdata_i[CFG1_INT_CLEAR] |-> ##[1:2] !monitor_run_o;
    endproperty
    property p_pulse_len;
        $fell(intrusion_pin_oe_o) |-> hold_q == INTRUSION_CYCLES;
    endproperty
    property p_pin_low;
        intrusion_pin_oe_o |-> !intrusion_pin_o;
    endproperty
    property p_fan_force;
        !thermal_alarm_n_i && !thermal_alarm_n_oe_o |-> ##[1:2] fan_level_o == FAN_FULL;
    endproperty
    property p_read_clear;
        s_rd(ADDR_STATUS_FIRST) ##1 s_rd(ADDR_STATUS_FIRST) |-> ##1 reg_rdata_o == 8'h00;
    endproperty
    property p_mirror_keep;
        s_rd(ADDR_STATUS_MIRROR_FIRST) ##1 s_rd(ADDR_STATUS_MIRROR_FIRST) |-> ##1 reg_rdata_o == $past(reg_rdata_o);
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("int output not released by clear bit");
    a_int_off: assert property (p_int_off) else $error("int output active while disabled");
    a_halt: assert property (p_halt) else $error("monitoring runs while clear bit set");
    a_pulse_len: assert property (p_pulse_len) else $error("intrusion pulse length wrong");
    a_pin_low: assert property (p_pin_low) else $error("intrusion line driven high");
    a_fan_force: assert property (p_fan_force) else $error("fan not forced full by thermal input");
    a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");
    a_mirror_keep: assert property (p_mirror_keep) else $error("mirror changed by read");
    c_int: cover property (int_n_o == 1'b0);
    c_pulse: cover property ($fell(intrusion_pin_oe_o));
    c_trip: cover property (thermal_alarm_n_oe_o && fan_level_o == FAN_FULL);
endmodule

bind monitor_irq_thermal_alarm_n monitor_irq_check #(.INTRUSION_CYCLES(INTRUSION_CYCLES)) chk_u (.clk_i(clk_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .meas_valid_i(meas_valid_i), .monitor_run_o(monitor_run_o),
    .intrusion_pin_o(intrusion_pin_o), .intrusion_pin_oe_o(intrusion_pin_oe_o),
    .thermal_alarm_n_i(thermal_alarm_n_i), .thermal_alarm_n_oe_o(thermal_alarm_n_oe_o), .int_n_o(int_n_o),
    .fan_level_o(fan_level_o));

// [sim/test_monitor_irq_thermal_alarm_n.sv]
// self-checking bench for the interrupt and thermal alarm block
// assumes the pin model and the bound checker; the intrusion pulse is shortened to 16 cycles
`timescale 1ns/1ps
module test_monitor_irq_thermal_alarm_n;
    import monitor_irq_pkg::*;
    localparam int IC = 16;
    localparam logic [4:0] VIDLE = 5'h07;
    logic clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, meas_valid_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, meas_value_i = 8'h00;
    logic [7:0] meas_high_i = 8'h80, meas_low_i = 8'h10, exp_q = 8'h00, exp2_q = 8'h00;
    logic [3:0] meas_index_i = 4'h0;
    logic [4:0] vci = VIDLE;
    logic intr_evt = 1'b0, ext_hot = 1'b0, chk_q = 1'b0, chk2_q = 1'b0;
    logic [7:0] reg_rdata_o, fan_level_o;
    logic monitor_run_o, intrusion_pin_i, intrusion_pin_o, intrusion_pin_oe_o, thermal_alarm_n_i;
    logic thermal_alarm_n_o, thermal_alarm_n_oe_o, int_n_o;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    always #4 clk_i = ~clk_i;
    monitor_irq_thermal_alarm_n #(.INTRUSION_CYCLES(IC)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .meas_valid_i(meas_valid_i), .meas_index_i(meas_index_i), .meas_value_i(meas_value_i),
        .meas_high_i(meas_high_i), .meas_low_i(meas_low_i), .monitor_run_o(monitor_run_o),
        .voltage_code_inputs_i(vci), .intrusion_pin_i(intrusion_pin_i), .intrusion_pin_o(intrusion_pin_o),
        .intrusion_pin_oe_o(intrusion_pin_oe_o), .thermal_alarm_n_i(thermal_alarm_n_i),
        .thermal_alarm_n_o(thermal_alarm_n_o), .thermal_alarm_n_oe_o(thermal_alarm_n_oe_o),
        .int_n_o(int_n_o), .fan_level_o(fan_level_o));
    monitor_pin_env env (.clk_i(clk_i), .intrusion_event_i(intr_evt), .intrusion_drive_i(intrusion_pin_o),
        .intrusion_oe_i(intrusion_pin_oe_o), .thermal_drive_i(thermal_alarm_n_o), .thermal_oe_i(thermal_alarm_n_oe_o),
        .ext_hot_i(ext_hot), .intrusion_pin_o(intrusion_pin_i), .thermal_pin_o(thermal_alarm_n_i));
    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // every strobe, address and data signal is set once per edge, so strobes may follow back to back
    task automatic cyc(input logic w, input logic r, input logic m, input logic c, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= w;
        reg_rd_i <= r;
        meas_valid_i <= m;
        chk_q <= c;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        meas_index_i <= a[3:0];
        meas_value_i <= d;
        exp_q <= d;
    endtask
    task automatic nop(input int n);
        repeat (n) cyc(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, 1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cyc(1'b0, 1'b1, 1'b0, 1'b1, a, e);
    endtask
    task automatic ms(input logic [7:0] i, input logic [7:0] v);
        cyc(1'b0, 1'b0, 1'b1, 1'b0, i, v);
    endtask
    task automatic lim(input logic [7:0] h, input logic [7:0] l);
        nop(1);
        meas_high_i <= h;
        meas_low_i <= l;
    endtask
    task automatic ci(input logic e);
        nop(3);
        #1 chk("int_n_o", {7'h00, e}, {7'h00, int_n_o});
    endtask
    task automatic co(input logic e);
        nop(3);
        #1 chk("thermal oe", {7'h00, e}, {7'h00, thermal_alarm_n_oe_o});
    endtask
    // read data stand only between the edge that takes the strobe and the next one,
    // so look at the falling edge in between rather than race the clearing edge
    always @(negedge clk_i)
    begin
        if (chk2_q)
            chk("rdata", exp2_q, reg_rdata_o);
    end
    always @(posedge clk_i)
    begin
        cycles++;
        chk2_q <= chk_q;
        exp2_q <= exp_q;
        if (cycles == 2000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(8'h40, 8'h08);
        rd(8'h13, 8'h7F);
        // local-channel hardware limits out of reach so the software-limit tests cannot trip them
        wr(8'h13, 8'hFF);
        wr(8'h17, 8'hFF);
        rd(8'h4A, 8'h00);
        wr(8'h4C, 8'hFF);
        rd(8'h4C, 8'h00);
        wr(8'h40, 8'h03);
        wr(8'h44, 8'h01);
        ms(8'h00, 8'h90);
        ci(1'b1);
        wr(8'h44, 8'h00);
        ci(1'b0);
        wr(8'h40, 8'h0B);
        ci(1'b1);
        wr(8'h40, 8'h03);
        ci(1'b0);
        wr(8'h40, 8'h01);
        ci(1'b1);
        rd(8'h41, 8'h01);
        rd(8'h41, 8'h00);
        wr(8'h40, 8'h03);
        ci(1'b1);
        ms(8'h04, 8'h90);
        rd(8'h4C, 8'h11);
        rd(8'h4C, 8'h11);
        ci(1'b0);
        co(1'b0);
        wr(8'h4A, 8'h01);
        ci(1'b1);
        wr(8'h4A, 8'h00);
        rd(8'h41, 8'h10);
        rd(8'h41, 8'h00);
        wr(8'h45, 8'h20);
        wr(8'h40, 8'h07);
        ms(8'h04, 8'h90);
        ci(1'b1);
        wr(8'h45, 8'h00);
        co(1'b1);
        rd(8'h43, 8'h20);
        co(1'b0);
        ms(8'h04, 8'h90);
        co(1'b1);
        wr(8'h40, 8'h47);
        co(1'b0);
        ms(8'h04, 8'h90);
        co(1'b0);
        wr(8'h40, 8'h07);
        ms(8'h04, 8'h90);
        co(1'b1);
        ms(8'h04, 8'h08);
        co(1'b0);
        wr(8'h4A, 8'h08);
        wr(8'h13, 8'h50);
        lim(8'hFF, 8'h00);
        ms(8'h04, 8'h60);
        ms(8'h04, 8'h60);
        co(1'b0);
        ms(8'h04, 8'h60);
        co(1'b1);
        chk("fan_level_o", 8'hFF, fan_level_o);
        rd(8'h47, 8'h01);
        ms(8'h04, 8'h4B);
        ms(8'h04, 8'h4B);
        co(1'b1);
        ms(8'h04, 8'h4B);
        co(1'b0);
        repeat (3) ms(8'h04, 8'h60);
        wr(8'h4A, 8'h09);
        co(1'b0);
        wr(8'h4A, 8'h00);
        lim(8'h80, 8'h10);
        cyc(1'b0, 1'b1, 1'b0, 1'b0, 8'h41, 8'h00);
        cyc(1'b0, 1'b1, 1'b0, 1'b0, 8'h43, 8'h00);
        ci(1'b1);
        nop(1);
        intr_evt <= 1'b1;
        nop(1);
        intr_evt <= 1'b0;
        ci(1'b0);
        wr(8'h46, 8'h80);
        nop(2);
        rd(8'h46, 8'h80);
        nop(IC);
        rd(8'h46, 8'h00);
        cyc(1'b0, 1'b1, 1'b0, 1'b0, 8'h43, 8'h00);
        ci(1'b1);
        nop(1);
        ext_hot <= 1'b1;
        nop(3);
        #1 chk("fan_level_o", 8'hFF, fan_level_o);
        ci(1'b0);
        nop(1);
        ext_hot <= 1'b0;
        cyc(1'b0, 1'b1, 1'b0, 1'b0, 8'h43, 8'h00);
        wr(8'h16, 8'hF0);
        wr(8'h4A, 8'hC0);
        ci(1'b1);
        for (int i = 0; i < 5; i++)
        begin
            nop(1);
            vci <= VIDLE ^ (5'h01 << i);
            ci(1'b0);
            nop(1);
            vci <= VIDLE;
            ci(1'b1);
        end
        wr(8'h16, 8'hE0);
        vci <= 5'h06;
        ci(1'b1);
        test_done();
    end
endmodule
